// File: core/tpo_regs.svh
// Purpose: register offsets and reset values of the pattern output unit
// Assumes: 16-bit byte addresses on the register port
// Notes:   included by its bare name
`ifndef TPO_REGS_SVH
`define TPO_REGS_SVH
`define TPO_ADR_MODE     16'hFFA0
`define TPO_ADR_TSEL     16'hFFA1
`define TPO_ADR_HI_EN    16'hFFA2
`define TPO_ADR_LO_EN    16'hFFA3
`define TPO_ADR_HI_ND    16'hFFA4
`define TPO_ADR_LO_ND    16'hFFA5
`define TPO_ADR_HI_ND2   16'hFFA6
`define TPO_ADR_LO_ND2   16'hFFA7
`define TPO_ADR_PA_DIR   16'hFFD1
`define TPO_ADR_PA_DATA  16'hFFD3
`define TPO_ADR_PB_DIR   16'hFFD4
`define TPO_ADR_PB_DATA  16'hFFD6
`define TPO_RST_MODE     8'hF0
`define TPO_RST_TSEL     8'hFF
`define TPO_RST_ZERO     8'h00
`define TPO_RD_ONES      8'hFF
`define TPO_MODE_RSV     8'hF0
`define TPO_PB_NOPIN     8'h40
`endif

// File: core/tpo_pkg.sv
// Purpose: shared types of the pattern output unit
// Assumes: four timer channels, each with match A and match B events
// Notes:   constants live in tpo_regs.svh
package tpo_pkg;
    typedef logic [1:0] tpo_chan_t;
    typedef struct packed {
        logic [3:0] cmp_a;
        logic [3:0] cmp_b;
    } tpo_match_t;
endpackage

// File: core/tpo_unit.sv
// Purpose: timed pattern output unit, 15 pulse pins in four 4-bit groups
// Assumes: timer match pulses are one cycle wide on sys_clk_i
// Notes:   hw_standby_i clears like reset, except rdata_o; software standby is ce_i low
//
// Behaviour
// [R01] Outputs form four 4-bit groups 3..0 updating independently or together.
// [R02] At most 15 usable bits; pattern output enabled per bit.
// [R03] Three full groups plus a 3-bit group; line 14 has no pin.
// [R04] Each group picks its trigger from four timer channels' matches.
// [R05] Non-overlap mode inserts a margin between successive pulse outputs.
// [R06] Port direction registers are 8-bit, write-only, reset to zero.
// [R07] Software sets direction to 1 for every pin used as pattern output.
// [R08] Port A bits 7..0 carry pattern outputs 7..0, groups 0 and 1.
// [R09] Port B carries outputs 15, 13..8; direction bit 6 is reserved.
// [R10] Port data bits enabled for pattern output are read-only.
// [R11] Groups 0,1 sharing a trigger: whole low next-data at one address.
// [R12] Groups 0,1 on different triggers: each nibble at its own address.
// [R13] Groups 2,3 sharing a trigger: whole high next-data at one address.
// [R14] Groups 2,3 on different triggers: each nibble at its own address.
// [R15] Mode register resets to F0, trigger select to FF.
// [R16] On the selected match, enabled next-data bits copy to port data.
// [R17] Unused companion next-data address reads all ones, ignores writes.
// [R18] Next-data and enables clear on reset and hardware standby only.
// [R19] Writes leave read-only port bits unchanged, other bits update.
`include "tpo_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tpo_unit
    import tpo_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // Clock, reset, freeze
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             hw_standby_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [7:0]       rdata_o,
    // Timer match events
    input  wire tpo_match_t       match_i,
    // Pattern pins
    output logic      [7:0]       porta_pin_o,
    output logic      [7:0]       porta_pin_oe_o,
    output logic      [7:0]       portb_pin_o,
    output logic      [7:0]       portb_pin_oe_o
);
    if (ADDR_W < 16) begin : g_chk
        $error("tpo_unit: ADDR_W must be at least 16");
    end

    logic [3:0] pattern_mode_reg;
    logic [7:0] trigger_select_reg;
    logic [7:0] high_next_enable;
    logic [7:0] low_next_enable;
    logic [7:0] high_next_data;
    logic [7:0] low_next_data;
    logic [7:0] porta_direction;
    logic [7:0] porta_output_data;
    logic [7:0] portb_direction;
    logic [7:0] portb_output_data;

    logic [15:0] a16;
    logic        clr;
    logic        wr_en;
    logic        same_lo;
    logic        same_hi;
    logic [15:0] cur_port;
    logic [15:0] en16;
    logic [15:0] nd16;
    logic [15:0] upd16;
    logic [15:0] base16;
    logic [15:0] next_port;
    logic [7:0]  next_rdata;

    assign a16   = addr_i[15:0];
    assign clr   = rst_i | hw_standby_i;
    assign wr_en = ce_i & wr_i;

    // Shared trigger decides how next-data is laid out in the map
    assign same_lo = trigger_select_reg[3:2] == trigger_select_reg[1:0];
    assign same_hi = trigger_select_reg[7:6] == trigger_select_reg[5:4];

    assign cur_port = {portb_output_data, porta_output_data};
    assign en16     = {high_next_enable, low_next_enable};
    assign nd16     = {high_next_data, low_next_data};

    // One trigger path per group, all may fire in the same cycle
    for (genvar g = 0; g < 4; g++) begin : g_grp
        tpo_chan_t  ch;
        logic       ev_a;
        logic       ev_b;
        logic [3:0] nd;
        assign ch   = trigger_select_reg[2*g+1:2*g]; // R04
        assign ev_a = match_i.cmp_a[ch];
        assign ev_b = match_i.cmp_b[ch];
        assign nd   = nd16[4*g+3:4*g];
        // Non-overlap: falls at match B, rises at match A, so the gap
        // between B and A is the margin between the two pulses
        assign upd16[4*g+3:4*g] = en16[4*g+3:4*g] &
            (pattern_mode_reg[g] ?
                (({4{ev_a}} & nd) | ({4{ev_b}} & ~nd)) : // R05
                {4{ev_a}}); // R01 R02 R16
    end

    always_comb begin
        base16 = cur_port;
        if (wr_en && a16 == `TPO_ADR_PA_DATA) begin
            base16[7:0] = (porta_output_data & low_next_enable) |
                          (wdata_i & ~low_next_enable); // R10 R19
        end else if (wr_en && a16 == `TPO_ADR_PB_DATA) begin
            base16[15:8] = (portb_output_data & high_next_enable) |
                           (wdata_i & ~high_next_enable); // R10 R19
        end
        next_port = (base16 & ~upd16) | (nd16 & upd16); // R16
    end

    // Port data: port A pins follow these flops directly
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            porta_output_data <= `TPO_RST_ZERO;
            portb_output_data <= `TPO_RST_ZERO;
        end else if (ce_i) begin
            porta_output_data <= next_port[7:0]; // R08
            portb_output_data <= next_port[15:8]; // R09
        end
    end

    // Direction registers, bit 6 of port B is not stored
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            porta_direction <= `TPO_RST_ZERO; // R06
            portb_direction <= `TPO_RST_ZERO; // R06
        end else if (wr_en && a16 == `TPO_ADR_PA_DIR) begin
            porta_direction <= wdata_i; // R06
        end else if (wr_en && a16 == `TPO_ADR_PB_DIR) begin
            portb_direction <= wdata_i & ~`TPO_PB_NOPIN; // R09
        end
    end

    // Mode and trigger select
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            pattern_mode_reg   <= 4'(`TPO_RST_MODE); // R15
            trigger_select_reg <= `TPO_RST_TSEL; // R15
        end else if (wr_en && a16 == `TPO_ADR_MODE) begin
            pattern_mode_reg <= wdata_i[3:0];
        end else if (wr_en && a16 == `TPO_ADR_TSEL) begin
            trigger_select_reg <= wdata_i;
        end
    end

    // Next-data enables; hold through software standby (ce_i low)
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            high_next_enable <= `TPO_RST_ZERO; // R18
            low_next_enable  <= `TPO_RST_ZERO; // R18
        end else if (wr_en && a16 == `TPO_ADR_HI_EN) begin
            high_next_enable <= wdata_i;
        end else if (wr_en && a16 == `TPO_ADR_LO_EN) begin
            low_next_enable <= wdata_i;
        end
    end

    // Low next-data; layout follows the group 0/1 triggers
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            low_next_data <= `TPO_RST_ZERO; // R18
        end else if (wr_en && a16 == `TPO_ADR_LO_ND) begin
            if (same_lo) begin
                low_next_data <= wdata_i; // R11
            end else begin
                low_next_data[7:4] <= wdata_i[7:4]; // R12
            end
        end else if (wr_en && a16 == `TPO_ADR_LO_ND2 && !same_lo) begin
            low_next_data[3:0] <= wdata_i[3:0]; // R12 R17
        end
    end

    // High next-data; layout follows the group 2/3 triggers
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            high_next_data <= `TPO_RST_ZERO; // R18
        end else if (wr_en && a16 == `TPO_ADR_HI_ND) begin
            if (same_hi) begin
                high_next_data <= wdata_i; // R13
            end else begin
                high_next_data[7:4] <= wdata_i[7:4]; // R14
            end
        end else if (wr_en && a16 == `TPO_ADR_HI_ND2 && !same_hi) begin
            high_next_data[3:0] <= wdata_i[3:0]; // R14 R17
        end
    end

    // Read mux; write-only and reserved places read as ones
    always_comb begin
        if (a16 == `TPO_ADR_MODE) begin
            next_rdata = `TPO_MODE_RSV | {4'h0, pattern_mode_reg};
        end else if (a16 == `TPO_ADR_TSEL) begin
            next_rdata = trigger_select_reg;
        end else if (a16 == `TPO_ADR_HI_EN) begin
            next_rdata = high_next_enable;
        end else if (a16 == `TPO_ADR_LO_EN) begin
            next_rdata = low_next_enable;
        end else if (a16 == `TPO_ADR_LO_ND) begin
            next_rdata = same_lo ? low_next_data :
                         {low_next_data[7:4], 4'hF}; // R11 R12
        end else if (a16 == `TPO_ADR_LO_ND2) begin
            next_rdata = same_lo ? `TPO_RD_ONES :
                         {4'hF, low_next_data[3:0]}; // R17
        end else if (a16 == `TPO_ADR_HI_ND) begin
            next_rdata = same_hi ? high_next_data :
                         {high_next_data[7:4], 4'hF}; // R13 R14
        end else if (a16 == `TPO_ADR_HI_ND2) begin
            next_rdata = same_hi ? `TPO_RD_ONES :
                         {4'hF, high_next_data[3:0]}; // R17
        end else if (a16 == `TPO_ADR_PA_DIR ||
                     a16 == `TPO_ADR_PB_DIR) begin
            next_rdata = `TPO_RD_ONES; // R06
        end else if (a16 == `TPO_ADR_PA_DATA) begin
            next_rdata = porta_output_data;
        end else if (a16 == `TPO_ADR_PB_DATA) begin
            next_rdata = portb_output_data;
        end else begin
            next_rdata = `TPO_RST_ZERO;
        end
    end

    // Read data stands for one cycle after each read strobe, zero otherwise; held while ce_i is low
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o <= `TPO_RST_ZERO;
        end else if (ce_i) begin
            rdata_o <= rd_i ? next_rdata : `TPO_RST_ZERO;
        end
    end

    // Line 14 has no pin: held low and never enabled
    assign porta_pin_o    = porta_output_data;
    assign porta_pin_oe_o = porta_direction; // R07
    assign portb_pin_oe_o = portb_direction; // R03

    // Own flop for the port B pins, so no gate sits behind the data flops
    always_ff @(posedge sys_clk_i) begin
        if (clr) begin
            portb_pin_o <= `TPO_RST_ZERO;
        end else if (ce_i) begin
            portb_pin_o <= next_port[15:8] & ~`TPO_PB_NOPIN; // R03
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i || hw_standby_i);

    logic wr_pa;
    logic fire0;
    assign wr_pa = wr_i && a16 == `TPO_ADR_PA_DATA;
    assign fire0 = |upd16[3:0];

    property p_copy_group0;
        ce_i && !wr_pa && !pattern_mode_reg[0] && low_next_enable[3:0] == 4'hF
        && match_i.cmp_a[trigger_select_reg[1:0]]
        |=> porta_output_data[3:0] == $past(low_next_data[3:0]);
    endproperty
    a_copy_group0: assert property (p_copy_group0) // R16
        else $error("enabled group 0 bits not loaded on match");

    property p_disabled_hold;
        ce_i && !wr_pa && low_next_enable == 8'h00
        |=> $stable(porta_output_data);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) // R02
        else $error("disabled port A bits changed");

    property p_readonly;
        ce_i && wr_pa && low_next_enable[0] && !upd16[0]
        |=> porta_output_data[0] == $past(porta_output_data[0]);
    endproperty
    a_readonly: assert property (p_readonly) // R10
        else $error("read-only port bit changed by a write");

    property p_writable;
        ce_i && wr_pa && !low_next_enable[1]
        |=> porta_output_data[1] == $past(wdata_i[1]);
    endproperty
    a_writable: assert property (p_writable) // R19
        else $error("writable port bit did not take write data");

    property p_nov_no_rise;
        ce_i && !wr_pa && pattern_mode_reg[0]
        && !match_i.cmp_a[trigger_select_reg[1:0]]
        |=> (porta_output_data[3:0] & ~$past(porta_output_data[3:0]))
            == 4'h0;
    endproperty
    a_nov_no_rise: assert property (p_nov_no_rise) // R05
        else $error("non-overlap output rose without match A");

    property p_lo_shared_rd;
        ce_i && rd_i && a16 == `TPO_ADR_LO_ND && same_lo
        |=> rdata_o == $past(low_next_data);
    endproperty
    a_lo_shared_rd: assert property (p_lo_shared_rd) // R11
        else $error("shared low next-data read wrong");

    property p_lo_split_rd;
        ce_i && rd_i && a16 == `TPO_ADR_LO_ND2 && !same_lo
        |=> rdata_o == {4'hF, $past(low_next_data[3:0])};
    endproperty
    a_lo_split_rd: assert property (p_lo_split_rd) // R12
        else $error("group 0 nibble read wrong");

    property p_hi_shared_rd;
        ce_i && rd_i && a16 == `TPO_ADR_HI_ND && same_hi
        |=> rdata_o == $past(high_next_data);
    endproperty
    a_hi_shared_rd: assert property (p_hi_shared_rd) // R13
        else $error("shared high next-data read wrong");

    property p_hi_split_rd;
        ce_i && rd_i && a16 == `TPO_ADR_HI_ND2 && !same_hi
        |=> rdata_o == {4'hF, $past(high_next_data[3:0])};
    endproperty
    a_hi_split_rd: assert property (p_hi_split_rd) // R14
        else $error("group 2 nibble read wrong");

    property p_resv_ones;
        ce_i && rd_i && a16 == `TPO_ADR_LO_ND2 && same_lo
        |=> rdata_o == 8'hFF;
    endproperty
    a_resv_ones: assert property (p_resv_ones) // R17
        else $error("reserved companion address not all ones");

    property p_hi_resv_ones;
        ce_i && rd_i && a16 == `TPO_ADR_HI_ND2 && same_hi
        |=> rdata_o == 8'hFF;
    endproperty
    a_hi_resv_ones: assert property (p_hi_resv_ones) // R17
        else $error("reserved high companion address not all ones");

    property p_mode_upper;
        ce_i && rd_i && a16 == `TPO_ADR_MODE |=> rdata_o[7:4] == 4'hF;
    endproperty
    a_mode_upper: assert property (p_mode_upper) // R15
        else $error("mode register upper bits not ones");

    property p_dir_oe;
        ce_i && wr_i && a16 == `TPO_ADR_PA_DIR
        |=> porta_pin_oe_o == $past(wdata_i);
    endproperty
    a_dir_oe: assert property (p_dir_oe) // R06
        else $error("port A direction did not drive enables");

    property p_no_pin14;
        portb_pin_oe_o[6] == 1'b0 && portb_pin_o[6] == 1'b0;
    endproperty
    a_no_pin14: assert property (p_no_pin14) // R03
        else $error("line 14 driven on a pin");

    property p_freeze;
        !ce_i |=> $stable(porta_output_data) && $stable(low_next_data);
    endproperty
    a_freeze: assert property (p_freeze) // R18
        else $error("state changed while frozen");

    c_fire0: cover property (ce_i && fire0);
    c_all_fire: cover property (ce_i && upd16 != 16'h0000
        && &{|upd16[3:0], |upd16[7:4], |upd16[11:8], |upd16[15:12]});
    c_nov: cover property (ce_i && pattern_mode_reg[0] && fire0);
    c_split: cover property (ce_i && !same_lo && wr_i
        && a16 == `TPO_ADR_LO_ND2);
endmodule
`default_nettype wire

// File: dv/tpo_pin_load.sv
// Purpose: external load on the pattern pins of the unit
// Assumes: every pin line carries a pull-down resistor
// Notes:   line 14 has no pin and always reads low
`timescale 1ns/100ps
`default_nettype none
module tpo_pin_load (
    // Port A and port B pins
    input  wire logic [7:0]  pa_pin_i,
    input  wire logic [7:0]  pa_oe_i,
    input  wire logic [7:0]  pb_pin_i,
    input  wire logic [7:0]  pb_oe_i,
    // Levels seen on pattern lines 15..0
    output logic      [15:0] line_o
);
    // An undriven line falls to the pull-down level, never the last value
    assign line_o[7:0]  = pa_pin_i & pa_oe_i;
    assign line_o[15]   = pb_pin_i[7] & pb_oe_i[7];
    assign line_o[14]   = 1'b0;
    assign line_o[13:8] = pb_pin_i[5:0] & pb_oe_i[5:0];
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Purpose: self-checking bench for the pattern output unit
// Assumes: register read data stand one cycle after the strobe
// Notes:   pin levels are judged through the pin load model
`include "tpo_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench
    import tpo_pkg::*;
;
    logic        sys_clk_i;
    logic        rst_i;
    logic        ce_i;
    logic        hw_standby_i;
    logic [15:0] addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    tpo_match_t  match_i;
    logic [7:0]  pa;
    logic [7:0]  pa_oe;
    logic [7:0]  pb;
    logic [7:0]  pb_oe;
    logic [15:0] lines;
    int          failures;
    int          total_checks;

    tpo_unit #(.ADDR_W(16)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .hw_standby_i(hw_standby_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .match_i(match_i),
        .porta_pin_o(pa), .porta_pin_oe_o(pa_oe),
        .portb_pin_o(pb), .portb_pin_oe_o(pb_oe));

    tpo_pin_load load (.pa_pin_i(pa), .pa_oe_i(pa_oe), .pb_pin_i(pb),
        .pb_oe_i(pb_oe), .line_o(lines));

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp,
                      input string what);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(what, exp, rdata_o);
    endtask

    // One-cycle match pulse; pins are settled when this returns
    task automatic fire(input logic [3:0] a, input logic [3:0] b);
        @(posedge sys_clk_i);
        match_i <= '{cmp_a: a, cmp_b: b};
        @(posedge sys_clk_i);
        match_i <= '0;
        #1;
    endtask

    task automatic t_reset;
        rd(`TPO_ADR_MODE, 8'hF0, "mode");
        rd(`TPO_ADR_TSEL, 8'hFF, "tsel");
        rd(`TPO_ADR_LO_EN, 8'h00, "lo_en");
        rd(`TPO_ADR_HI_ND, 8'h00, "hi_nd");
        rd(`TPO_ADR_PA_DATA, 8'h00, "pa_data");
        rd(`TPO_ADR_PA_DIR, 8'hFF, "pa_dir");
        rd(16'hFF00, 8'h00, "unmapped");
        chk("pa_oe", 8'h00, pa_oe);
        wr(`TPO_ADR_MODE, 8'h00);
        rd(`TPO_ADR_MODE, 8'hF0, "mode");
    endtask

    task automatic t_dir;
        wr(`TPO_ADR_PA_DIR, 8'hFF);
        wr(`TPO_ADR_PB_DIR, 8'hFF);
        chk("pa_oe", 8'hFF, pa_oe);
        chk("pb_oe", 8'hBF, pb_oe);
    endtask

    task automatic t_shared;
        wr(`TPO_ADR_LO_EN, 8'h0F);
        wr(`TPO_ADR_LO_ND, 8'h5A);
        wr(`TPO_ADR_LO_ND2, 8'h00);
        rd(`TPO_ADR_LO_ND2, 8'hFF, "lo_nd2");
        rd(`TPO_ADR_LO_ND, 8'h5A, "lo_nd");
        fire(4'h8, 4'h0);
        chk("lines lo", 8'h0A, lines[7:0]);
        wr(`TPO_ADR_PA_DATA, 8'hFF);
        chk("lines lo", 8'hFA, lines[7:0]);
        rd(`TPO_ADR_PA_DATA, 8'hFA, "pa_data");
        wr(`TPO_ADR_HI_EN, 8'hFF);
        wr(`TPO_ADR_HI_ND, 8'hC3);
        rd(`TPO_ADR_HI_ND2, 8'hFF, "hi_nd2");
        fire(4'h8, 4'h0);
        chk("lines hi", 8'h83, lines[15:8]);
    endtask

    // Groups on channels 0..3 in turn
    task automatic t_split;
        wr(`TPO_ADR_TSEL, 8'hE4);
        wr(`TPO_ADR_LO_EN, 8'hFF);
        wr(`TPO_ADR_LO_ND, 8'h90);
        wr(`TPO_ADR_LO_ND2, 8'h06);
        rd(`TPO_ADR_LO_ND, 8'h9F, "lo_nd");
        rd(`TPO_ADR_LO_ND2, 8'hF6, "lo_nd2");
        fire(4'h1, 4'h0);
        chk("lines lo", 8'hF6, lines[7:0]);
        fire(4'h2, 4'h0);
        chk("lines lo", 8'h96, lines[7:0]);
        wr(`TPO_ADR_HI_ND, 8'hD0);
        wr(`TPO_ADR_HI_ND2, 8'h0C);
        rd(`TPO_ADR_HI_ND, 8'hDF, "hi_nd");
        fire(4'hC, 4'h0);
        chk("lines hi", 8'h9C, lines[15:8]);
        rd(`TPO_ADR_PB_DATA, 8'hDC, "pb_data");
    endtask

    task automatic t_nonoverlap;
        wr(`TPO_ADR_MODE, 8'h01);
        wr(`TPO_ADR_LO_ND2, 8'h05);
        fire(4'h0, 4'h1);
        chk("lines lo", 8'h94, lines[7:0]);
        fire(4'h1, 4'h0);
        chk("lines lo", 8'h95, lines[7:0]);
    endtask

    task automatic t_standby;
        wr(`TPO_ADR_LO_ND, 8'h30);
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        fire(4'h2, 4'h0);
        chk("lines lo", 8'h95, lines[7:0]);
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        rd(`TPO_ADR_LO_EN, 8'hFF, "lo_en");
        fire(4'h2, 4'h0);
        chk("lines lo", 8'h35, lines[7:0]);
        @(posedge sys_clk_i);
        hw_standby_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        hw_standby_i <= 1'b0;
        rd(`TPO_ADR_LO_EN, 8'h00, "lo_en");
        rd(`TPO_ADR_LO_ND, 8'h00, "lo_nd");
        rd(`TPO_ADR_TSEL, 8'hFF, "tsel");
        chk("pa_oe", 8'h00, pa_oe);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        failures++;
        $display("Error watchdog expected finish seen timeout");
        stop_test;
    end

    initial begin
        failures     = 0;
        total_checks = 0;
        rst_i        = 1'b1;
        ce_i         = 1'b1;
        hw_standby_i = 1'b0;
        addr_i       = 16'h0000;
        wdata_i      = 8'h00;
        wr_i         = 1'b0;
        rd_i         = 1'b0;
        match_i      = '0;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_dir;
        t_shared;
        t_split;
        t_nonoverlap;
        t_standby;
        stop_test;
    end
endmodule
`default_nettype wire
